// *** hw/serial_slave_access.sv ***
// serial slave parameter access: frames, check word, commands
// assumes a byte receiver and transmitter on the same clock
//
// Overview of operation
// R1: read command 03H serves one to twelve words
// R2: host sends address, command, start, count, check
// R3: read reply: address, command, byte count, words, check
// R4: command 06H writes one word to address
// R5: write reply echoes the request unchanged
// R6: check word appended, recomputed and compared
// R7: check register starts all ones, data bits only
// R8: per byte xor, eight shifts with polynomial a001
// R9: parameter address is group high, index low
// R10: top address bit writes RAM only; reads invalid
// R11: command 07H also writes RAM only
// R12: run-control values 1 to 7 decoded
// R13: silence ends frame; long pause discards partial
// R14: accept own address or broadcast, never answer broadcast
// R15: bad check or foreign address silently dropped
`timescale 1ns/1ps
`include "slave_access_consts.svh"

module serial_slave_access #(
   parameter int CHAR_CYCLES = `CHAR_TIME_PS / `CLK_PERIOD_PS,
   parameter int FIFO_DEPTH  = 16
) (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      reset,
   // configured station address
   input  wire logic [7:0]                slaveAddr,
   // received bytes from the receiver
   input  wire logic                      rxValid,
   input  wire logic [7:0]                rxData,
   // bytes to the transmitter
   output logic                           txValid,
   output logic      [7:0]                txData,
   input  wire logic                      txReady,
   // decoded run command, one-cycle pulse
   output slave_access_pkg::run_event_t   runEvent,
   // nonvolatile store request, one-cycle pulse
   output slave_access_pkg::store_req_t   storeReq
);

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int GAP_ABORT = (CHAR_CYCLES * `GAP_ABORT_TENTHS + 9) / 10;
   localparam int GAP_END   = (CHAR_CYCLES * `GAP_END_TENTHS + 9) / 10;

   // refuse a character time or fifo depth the logic cannot serve
   if (CHAR_CYCLES < 1 || FIFO_DEPTH < 16) begin : gBadParams
      $error("serial_slave_access: bad character time or fifo depth");
   end

   // ----------------------------------------------------------------
   // check word step over one byte
   // ----------------------------------------------------------------
   function automatic logic [15:0] crcByte(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b}; // R8
      for (int i = 0; i < 8; i++) begin
         if (c[0])
            c = (c >> 1) ^ `CRC_POLY; // R8
         else
            c = c >> 1;
      end
      return c;
   endfunction : crcByte

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   slave_access_pkg::state_t state_r;
   logic [31:0] silence_r;
   logic [3:0]  rxCount_r;
   logic        overflow_r;
   logic [7:0]  rxBuf_r [8];
   logic [15:0] rxCrc_r;
   logic [15:0] runCtrl_r;
   logic [15:0] paramMem [4096];
   logic [4:0]  txIdx_r;
   logic [4:0]  txLen_r;
   logic [15:0] txCrc_r;
   logic        echo_r;
   logic [15:0] rdStart_r;

   logic        frameEnd;
   logic        frameGood;
   logic [7:0]  cmdByte;
   logic [15:0] reqAddr;
   logic [15:0] reqValue;
   logic        forUs;
   logic        isBcast;
   logic        readOk;
   logic        writeOk;
   logic        ramOnly;
   logic        memWe;
   logic [11:0] memAddr;
   logic [7:0]  txByte;
   logic        pushByte;
   logic        fifoInReady;
   logic [15:0] wordAddr;
   logic [15:0] wordVal;
   logic [4:0]  dataIdx;

   // ----------------------------------------------------------------
   // frame delimiting
   // ----------------------------------------------------------------

   // bus silence since the last byte, saturating at the end gap
   always_ff @(posedge clock) begin
      if (reset)
         silence_r <= '0;
      else if (rxValid)
         silence_r <= '0; // R13
      else if (silence_r != 32'(GAP_END))
         silence_r <= silence_r + 32'h1;
   end

   // end of frame when silence just reaches the end gap
   assign frameEnd = !rxValid && silence_r == 32'(GAP_END - 1); // R13

   // a full request with a zero residue passes the check
   assign frameGood = frameEnd && rxCount_r == `REQ_FRAME_LEN && !overflow_r
                      && rxCrc_r == 16'h0000; // R6 R15

   // byte collection; bytes during execution or reply are ignored
   always_ff @(posedge clock) begin
      if (reset) begin
         rxCount_r  <= '0;
         overflow_r <= 1'b0;
         rxCrc_r    <= `CRC_INIT;
      end else if (state_r == slave_access_pkg::ST_LISTEN) begin
         if (rxValid) begin
            if (rxCount_r == 4'h0 || silence_r > 32'(GAP_ABORT)) begin
               rxCount_r  <= 4'h1; // R13
               overflow_r <= 1'b0;
               rxCrc_r    <= crcByte(`CRC_INIT, rxData); // R7
            end else if (rxCount_r == `REQ_FRAME_LEN) begin
               overflow_r <= 1'b1;
            end else begin
               rxCount_r <= rxCount_r + 4'h1;
               rxCrc_r   <= crcByte(rxCrc_r, rxData); // R6
            end
         end else if (frameEnd) begin
            rxCount_r <= '0;
         end
      end
   end

   // received bytes stay put until the next listen phase
   always_ff @(posedge clock) begin
      if (state_r == slave_access_pkg::ST_LISTEN && rxValid) begin
         if (rxCount_r == 4'h0 || silence_r > 32'(GAP_ABORT))
            rxBuf_r[0] <= rxData;
         else if (rxCount_r != `REQ_FRAME_LEN)
            rxBuf_r[rxCount_r[2:0]] <= rxData; // R2 R4
      end
   end

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   assign cmdByte  = rxBuf_r[1];
   assign reqAddr  = {rxBuf_r[2], rxBuf_r[3]}; // R9
   assign reqValue = {rxBuf_r[4], rxBuf_r[5]};
   assign isBcast  = rxBuf_r[0] == `ADDR_BROADCAST;
   assign forUs    = isBcast || (rxBuf_r[0] == slaveAddr && slaveAddr != `ADDR_BROADCAST
                     && slaveAddr <= `ADDR_SLAVE_MAX); // R14 R15
   assign ramOnly  = reqAddr[`RAM_ONLY_BIT] || cmdByte == `CMD_WRITE_RAM; // R10 R11
   assign memAddr  = reqAddr[11:0];

   // reads: one to twelve words, inside the parameter space or the run word
   always_comb begin
      readOk = 1'b0;
      if (cmdByte == `CMD_READ_WORDS && reqValue != 16'h0000
          && reqValue <= `MAX_READ_WORDS) begin // R1
         if (reqAddr[15:12] == 4'h0)
            readOk = ({4'h0, reqAddr[11:0]} + reqValue) <= 16'h1000; // R9 R10
         else if (reqAddr == `RUN_CTRL_ADDR)
            readOk = reqValue == 16'h0001;
      end
   end

   // writes: parameter space, with or without the RAM-only bit, or run word
   always_comb begin
      writeOk = 1'b0;
      if (cmdByte == `CMD_WRITE_WORD || cmdByte == `CMD_WRITE_RAM) begin // R4 R11
         if (reqAddr[14:12] == 3'h0)
            writeOk = reqAddr[11:8] <= `PARAM_GROUP_MAX; // R9
         else if (reqAddr == `RUN_CTRL_ADDR)
            writeOk = 1'b1;
      end
   end

   assign memWe = state_r == slave_access_pkg::ST_EXECUTE && writeOk
                  && reqAddr[14:12] == 3'h0;

   // working copy of the parameters
   always_ff @(posedge clock) begin
      if (memWe)
         paramMem[memAddr] <= reqValue; // R10 R11
   end

   // run-control word and its decoded pulse
   always_ff @(posedge clock) begin
      if (reset) begin
         runCtrl_r <= `RUN_CTRL_RESET;
         runEvent  <= '0;
      end else begin
         runEvent.valid <= 1'b0;
         if (state_r == slave_access_pkg::ST_EXECUTE && writeOk
             && reqAddr == `RUN_CTRL_ADDR) begin
            runCtrl_r <= reqValue;
            if (reqValue >= 16'h0001 && reqValue <= 16'h0007) begin // R12
               runEvent.valid <= 1'b1;
               runEvent.cmd   <= slave_access_pkg::run_cmd_t'(reqValue[2:0]); // R12
            end
         end
      end
   end

   // store request for parameter writes that are not RAM-only
   always_ff @(posedge clock) begin
      if (reset) begin
         storeReq <= '0;
      end else begin
         storeReq.valid <= memWe && !ramOnly; // R10 R11
         storeReq.addr  <= memAddr;
         storeReq.data  <= reqValue;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         state_r   <= slave_access_pkg::ST_LISTEN;
         echo_r    <= 1'b0;
         txLen_r   <= '0;
         rdStart_r <= '0;
      end else begin
         unique case (state_r)
            slave_access_pkg::ST_LISTEN: begin
               if (frameGood && forUs) // R15
                  state_r <= slave_access_pkg::ST_EXECUTE;
            end
            slave_access_pkg::ST_EXECUTE: begin
               echo_r    <= cmdByte != `CMD_READ_WORDS;
               rdStart_r <= reqAddr;
               txLen_r   <= (cmdByte == `CMD_READ_WORDS) ?
                            `READ_HDR_LEN + 5'({reqValue[3:0], 1'b0}) + 5'h02 // R3
                            : 5'(`REQ_FRAME_LEN); // R5
               if (!isBcast && (readOk || writeOk)) // R14 R10
                  state_r <= slave_access_pkg::ST_REPLY;
               else
                  state_r <= slave_access_pkg::ST_LISTEN;
            end
            slave_access_pkg::ST_REPLY: begin
               if (pushByte && txIdx_r == txLen_r - 5'h01)
                  state_r <= slave_access_pkg::ST_LISTEN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // reply byte generation
   // ----------------------------------------------------------------
   assign dataIdx  = txIdx_r - `READ_HDR_LEN;
   assign wordAddr = rdStart_r + {12'h000, dataIdx[4:1]};
   assign wordVal  = (wordAddr == `RUN_CTRL_ADDR) ? runCtrl_r : paramMem[wordAddr[11:0]];

   // next byte of the reply
   always_comb begin
      txByte = 8'h00;
      if (echo_r)
         txByte = rxBuf_r[txIdx_r[2:0]]; // R5
      else if (txIdx_r < 5'h02)
         txByte = rxBuf_r[txIdx_r[2:0]]; // R3
      else if (txIdx_r == 5'h02)
         txByte = 8'(txLen_r - 5'h05); // R3
      else if (txIdx_r == txLen_r - 5'h02)
         txByte = txCrc_r[7:0]; // R6
      else if (txIdx_r == txLen_r - 5'h01)
         txByte = txCrc_r[15:8]; // R6
      else
         txByte = dataIdx[0] ? wordVal[7:0] : wordVal[15:8]; // R3
   end

   assign pushByte = state_r == slave_access_pkg::ST_REPLY && fifoInReady;

   // reply index and running check word
   always_ff @(posedge clock) begin
      if (reset || state_r != slave_access_pkg::ST_REPLY) begin
         txIdx_r <= '0;
         txCrc_r <= `CRC_INIT; // R7
      end else if (pushByte) begin
         txIdx_r <= txIdx_r + 5'h01;
         // frozen once the check bytes start, so the high byte is not polluted
         if (txIdx_r < txLen_r - 5'h02)
            txCrc_r <= crcByte(txCrc_r, txByte); // R6
      end
   end

   // ----------------------------------------------------------------
   // transmit buffer
   // ----------------------------------------------------------------
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) txFifo (
      .clock    (clock),
      .reset    (reset),
      .inValid  (pushByte),
      .inData   (txByte),
      .inReady  (fifoInReady),
      .outValid (txValid),
      .outData  (txData),
      .outReady (txReady)
   );

endmodule : serial_slave_access

// *** hw/slave_access_consts.svh ***
// constants for the serial parameter access block
// assumes inclusion by bare name from the main module
`ifndef SLAVE_ACCESS_CONSTS_SVH
`define SLAVE_ACCESS_CONSTS_SVH

// ----------------------------------------------------------------
// command codes and addresses
// ----------------------------------------------------------------
`define CMD_READ_WORDS   8'h03
`define CMD_WRITE_WORD   8'h06
`define CMD_WRITE_RAM    8'h07
`define ADDR_BROADCAST   8'h00
`define ADDR_SLAVE_MAX   8'hf7
`define RUN_CTRL_ADDR    16'h1000
`define RUN_CTRL_RESET   16'h0000
`define RAM_ONLY_BIT     15
`define PARAM_GROUP_MAX  4'hf

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define REQ_FRAME_LEN    4'h8
`define MAX_READ_WORDS   16'h000c
`define READ_HDR_LEN     5'h03

// ----------------------------------------------------------------
// check word
// ----------------------------------------------------------------
`define CRC_INIT         16'hffff
`define CRC_POLY         16'ha001

// ----------------------------------------------------------------
// timing: one character of 11 bits at 9600 baud
// ----------------------------------------------------------------
`define CLK_PERIOD_PS    4000
`define CHAR_TIME_PS     1145834000
`define GAP_ABORT_TENTHS 15
`define GAP_END_TENTHS   35

`endif

// *** hw/slave_access_pkg.sv ***
// types shared by the serial parameter access block
// assumes the constants header sits on the include path
package slave_access_pkg;

   // ----------------------------------------------------------------
   // run-control codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RUN_NONE      = 3'h0,
      RUN_FWD       = 3'h1,
      RUN_REV       = 3'h2,
      RUN_JOG_FWD   = 3'h3,
      RUN_JOG_REV   = 3'h4,
      RUN_STOP      = 3'h5,
      RUN_COAST     = 3'h6,
      RUN_FAULT_RST = 3'h7
   } run_cmd_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic     valid;
      run_cmd_t cmd;
   } run_event_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic [15:0] data;
   } store_req_t;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_LISTEN  = 3'b001,
      ST_EXECUTE = 3'b010,
      ST_REPLY   = 3'b100
   } state_t;

endpackage : slave_access_pkg

// *** hw/byte_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // filling side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // draining side
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_r;
   logic [AW:0]      rdPtr_r;
   logic             push;
   logic             pop;

   // refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gBadParams
      $error("byte_fifo: depth must be a power of two, width positive");
   end

   // full when pointers differ only in the wrap bit
   assign inReady  = (wrPtr_r ^ rdPtr_r) != {1'b1, {AW{1'b0}}};
   assign outValid = wrPtr_r != rdPtr_r;
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outData  = mem[rdPtr_r[AW-1:0]];

   // write side
   always_ff @(posedge clock) begin
      if (push)
         mem[wrPtr_r[AW-1:0]] <= inData;
   end

   // pointers
   always_ff @(posedge clock) begin
      if (reset) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push)
            wrPtr_r <= wrPtr_r + 1'b1;
         if (pop)
            rdPtr_r <= rdPtr_r + 1'b1;
      end
   end

endmodule : byte_fifo

// *** bench/serial_slave_access_checker.sv ***
// checker for the serial parameter access block
// assumes a bind onto the top module, one clock, synchronous reset
`timescale 1ns/1ps

module serial_slave_access_checker #(
   parameter int CHAR_CYCLES = 20
) (
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   reset,
   // link side
   input  wire logic [7:0]             slaveAddr,
   input  wire logic                   rxValid,
   input  wire logic [7:0]             rxData,
   input  wire logic                   txValid,
   input  wire logic [7:0]             txData,
   input  wire logic                   txReady,
   // event outputs
   input  slave_access_pkg::run_event_t runEvent,
   input  slave_access_pkg::store_req_t storeReq
);
   localparam int GAP_END = (CHAR_CYCLES * 35 + 9) / 10;
   logic [31:0] quietCnt_r;
   logic [63:0] frame_r;
   logic        firstPend_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // idle cycles since the last received byte, saturating
   always_ff @(posedge clock) begin
      if (reset || rxValid) begin
         quietCnt_r <= 32'h0;
      end else if (quietCnt_r < 32'(GAP_END + 8)) begin
         quietCnt_r <= quietCnt_r + 32'h1;
      end
   end

   // last eight received bytes, newest at the bottom
   always_ff @(posedge clock) begin
      if (rxValid) begin
         frame_r <= {frame_r[55:0], rxData};
      end
   end

   // a reply byte is still owed its first position
   always_ff @(posedge clock) begin
      if (reset) begin
         firstPend_r <= 1'b0;
      end else if (rxValid) begin
         firstPend_r <= 1'b1;
      end else if (txValid && txReady) begin
         firstPend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sequences and properties
   // ----------------------------------------------------------------
   sequence sStall;
      txValid && !txReady;
   endsequence
   sequence sStorePulse;
      storeReq.valid ##1 !storeReq.valid;
   endsequence

   AST_RESET_IDLE: assert property ($fell(reset) |-> !txValid && !runEvent.valid && !storeReq.valid)
      else $error("outputs active right after reset");
   AST_REPLY_GAP: assert property ($rose(txValid) |-> quietCnt_r >= 32'(GAP_END))
      else $error("reply started before the frame gap");
   AST_EVENT_GAP: assert property (runEvent.valid |-> quietCnt_r >= 32'(GAP_END))
      else $error("run event before the frame gap");
   AST_STORE_FIELDS: assert property (storeReq.valid |-> storeReq.addr == frame_r[43:32]
      && storeReq.data == frame_r[31:16] && frame_r[55:48] == 8'h06 && !frame_r[47])
      else $error("store request does not match the write frame");
   AST_RUN_DECODE: assert property (runEvent.valid |-> frame_r[47:32] == 16'h1000
      && frame_r[31:19] == 13'h0 && runEvent.cmd == frame_r[18:16] && frame_r[18:16] != 3'h0)
      else $error("run event does not match the written value");
   AST_RUN_PULSE: assert property (runEvent.valid |=> !runEvent.valid)
      else $error("run event longer than one cycle");
   AST_STORE_PULSE: assert property (storeReq.valid |-> sStorePulse)
      else $error("store request longer than one cycle");
   AST_FIRST_BYTE: assert property (txValid && txReady && firstPend_r
      |-> txData == frame_r[63:56] && txData != 8'h00)
      else $error("reply does not open with the station address");
   AST_TX_HOLD: assert property (sStall |=> txValid && $stable(txData))
      else $error("reply byte changed while stalled");
endmodule : serial_slave_access_checker

bind serial_slave_access serial_slave_access_checker #(.CHAR_CYCLES(CHAR_CYCLES)) chk (
   .clock(clock), .reset(reset), .slaveAddr(slaveAddr), .rxValid(rxValid), .rxData(rxData),
   .txValid(txValid), .txData(txData), .txReady(txReady), .runEvent(runEvent),
   .storeReq(storeReq));

// *** bench/host_model.sv ***
// host side of the serial link: sends request bytes, takes replies
// assumes the bench calls send and supplies the stall pattern
`timescale 1ns/1ps

module host_model (
   // clock
   input  wire logic       clock,
   // stall request from the bench
   input  wire logic       stall,
   // bytes towards the block
   output logic            rxValid,
   output logic [7:0]      rxData,
   // transmitter acceptance
   output logic            txReady
);
   // transmitter busy while stalled
   assign txReady = ~stall;

   initial begin
      rxValid = 1'b0;
      rxData  = 8'h00;
   end

   // one strobe per byte, line scrambled between strobes
   task automatic send(input logic [7:0] f[$]);
      foreach (f[i]) begin
         @(posedge clock);
         #1;
         rxValid = 1'b1;
         rxData  = f[i];
         @(posedge clock);
         #1;
         rxValid = 1'b0;
         rxData  = ~f[i];
         repeat (2) @(posedge clock);
      end
   endtask : send
endmodule : host_model

// *** bench/tb.sv ***
// self-checking bench for the serial parameter access block
// assumes the host model and the bound checker are compiled before
`timescale 1ns/1ps

module tb;
   localparam int CHAR = 20;
   logic        clock;
   logic        reset;
   logic [7:0]  slaveAddr;
   logic        rxValid;
   logic [7:0]  rxData;
   logic        txValid;
   logic [7:0]  txData;
   logic        txReady;
   logic        stall;
   logic [31:0] rnd;
   int          failures = 0;
   int          n_checks = 0;
   int          cycles   = 0;
   logic [7:0]  expQ[$];
   logic [15:0] mem[logic [15:0]];
   slave_access_pkg::run_event_t runEvent;
   slave_access_pkg::store_req_t storeReq;
   slave_access_pkg::store_req_t stQ[$];
   slave_access_pkg::run_event_t evQ[$];

   serial_slave_access #(.CHAR_CYCLES(CHAR), .FIFO_DEPTH(16)) uut (.clock(clock), .reset(reset),
      .slaveAddr(slaveAddr), .rxValid(rxValid), .rxData(rxData), .txValid(txValid),
      .txData(txData), .txReady(txReady), .runEvent(runEvent), .storeReq(storeReq));
   host_model host (.clock(clock), .stall(stall), .rxValid(rxValid), .rxData(rxData),
      .txReady(txReady));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
         end
      end
      return c;
   endfunction : crc16

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   // send one request, note its reply, wait for it and for silence
   task automatic run_frame(input logic [7:0] req[$], input logic [7:0] rsp[$], input bit bad);
      logic [15:0] c;
      int          k;
      c = crc16(req);
      req.push_back(c[7:0] ^ {7'h00, bad});
      req.push_back(c[15:8]);
      if (rsp.size() > 0) begin
         c = crc16(rsp);
         rsp.push_back(c[7:0]);
         rsp.push_back(c[15:8]);
      end
      foreach (rsp[i]) expQ.push_back(rsp[i]);
      host.send(req);
      k = 0;
      while (expQ.size() > 0 && k < 3000) begin
         @(posedge clock);
         k++;
      end
      repeat (150) @(posedge clock);
      check(32'(expQ.size()), 32'h0);
      check(32'(stQ.size()), 32'h0);
      check(32'(evQ.size()), 32'h0);
      expQ.delete();
      $display("done frame cmd %h addr %h%h", req[1], req[2], req[3]);
   endtask : run_frame

   task automatic wr(input logic [7:0] dst, cmd, input logic [15:0] a, d, input bit bad);
      logic [7:0] req[$];
      logic [7:0] rsp[$];
      bit         ok;
      req = '{dst, cmd, a[15:8], a[7:0], d[15:8], d[7:0]};
      ok  = !bad && (dst == slaveAddr || dst == 8'h00);
      if (ok) mem[{1'b0, a[14:0]}] = d;
      if (ok && dst != 8'h00) rsp = req;
      if (ok && cmd == 8'h06 && a[15:12] == 4'h0) stQ.push_back({1'b1, a[11:0], d});
      if (ok && a == 16'h1000 && d > 16'h0 && d < 16'h8) evQ.push_back({1'b1, d[2:0]});
      run_frame(req, rsp, bad);
   endtask : wr

   task automatic rd(input logic [15:0] a, input int n, input bit ok);
      logic [7:0] req[$];
      logic [7:0] rsp[$];
      req = '{slaveAddr, 8'h03, a[15:8], a[7:0], 8'h00, 8'(n)};
      if (ok) begin
         rsp = '{slaveAddr, 8'h03, 8'(2 * n)};
         for (int i = 0; i < n; i++) begin
            rsp.push_back(mem[a + 16'(i)][15:8]);
            rsp.push_back(mem[a + 16'(i)][7:0]);
         end
      end
      run_frame(req, rsp, 1'b0);
   endtask : rd

   // ----------------------------------------------------------------
   // clock, stall pattern, watchers, timeout
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // random transmitter stalls just after each edge
   always @(posedge clock) begin
      #1;
      rnd   = lfsr(rnd);
      stall = (rnd[2:0] < 3'h3);
   end

   // reply bytes against the oldest note
   always @(posedge clock) begin
      if (!reset && txValid === 1'b1 && txReady === 1'b1) begin
         if (expQ.size() > 0) check(32'(txData), 32'(expQ.pop_front()));
         else check(32'(txData), 32'hxx);
      end
   end

   // store and run pulses against their notes
   always @(posedge clock) begin
      if (storeReq.valid === 1'b1) begin
         if (stQ.size() > 0) check(32'(storeReq), 32'(stQ.pop_front()));
         else check(32'(storeReq), 32'hx);
      end
      if (runEvent.valid === 1'b1) begin
         if (evQ.size() > 0) check(32'(runEvent), 32'(evQ.pop_front()));
         else check(32'(runEvent), 32'hx);
      end
   end

   // bounded run time
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset     = 1'b1;
      slaveAddr = 8'h11;
      stall     = 1'b0;
      rnd       = 32'h62a0cfe0;
      repeat (2) @(posedge clock);
      #1;
      reset = 1'b0;
      mem[16'h1000] = 16'h0000;
      rd(16'h1000, 1, 1'b1);
      wr(slaveAddr, 8'h06, 16'h0003, 16'h1388, 1'b0);
      for (int i = 0; i < 12; i++) wr(slaveAddr, 8'h06, 16'h0a10 + 16'(i), rnd[15:0], 1'b0);
      rd(16'h0a10, 12, 1'b1);
      rd(16'h0a10, 13, 1'b0);
      rd(16'h8a10, 1, 1'b0);
      wr(slaveAddr, 8'h07, 16'h0a10, 16'hbeef, 1'b0);
      wr(slaveAddr, 8'h06, 16'h8a11, 16'h1234, 1'b0);
      rd(16'h0a10, 2, 1'b1);
      wr(slaveAddr, 8'h06, 16'h0a12, 16'h0f0f, 1'b1);
      wr(8'h12, 8'h06, 16'h0a12, 16'h0f0f, 1'b0);
      wr(8'h00, 8'h06, 16'h0a12, 16'h5a5a, 1'b0);
      rd(16'h0a12, 1, 1'b1);
      host.send('{slaveAddr, 8'h03, 8'h0a});
      repeat (40) @(posedge clock);
      rd(16'h0003, 1, 1'b1);
      for (int v = 1; v < 9; v++) wr(slaveAddr, 8'h06, 16'h1000, 16'(v), 1'b0);
      rd(16'h1000, 1, 1'b1);
      end_of_test();
   end
endmodule : tb
